// [rtl/sac_pkg.sv]
// Shared constants and carriers of the serial converter interface.
// Assumes one 40 ns core clock and a serial clock from the master.
package sac_pkg;
    // ==========================================================
    // Frame geometry
    localparam int CTL_BITS = 8; // Control byte length
    localparam int FRAME_BITS = 16; // Bits read out per result
    localparam int DEC_BITS = 12; // Result plus two sub-LSB bits
    localparam logic [3:0] TRACK_FIRST = 4'h4; // Bits in before tracking starts
    localparam logic [3:0] CTL_LAST = 4'h7; // Bit count when the last bit enters
    localparam logic [4:0] REARM_POS = 5'h08; // Bits out once result bit 3 is out
    localparam logic [4:0] TRAIL_POS = 5'h0E; // First trailing zero position
    localparam logic [4:0] FRAME_END = 5'h10; // Last output position
    localparam logic [11:0] SIGN_FLIP = 12'h800; // Offset binary to two's complement
    // ==========================================================
    // Clock mode field of the control byte
    localparam logic [1:0] MODE_FULL_PD = 2'h0;
    localparam logic [1:0] MODE_FAST_PD = 2'h1;
    localparam logic [1:0] MODE_INT_CLK = 2'h2;
    localparam logic [1:0] MODE_EXT_CLK = 2'h3;
    // ==========================================================
    // Reset values
    localparam logic RST_EXT_MODE = 1'h0; // Internal clock mode after reset
    localparam logic RST_STROBE = 1'h1; // Strobe high after reset
    // ==========================================================
    // Timing: longest internal conversion, rounded down to cycles
    localparam int CONV_TIME_NS = 7500;
    localparam int CORE_PERIOD_NS = 40;
    localparam int CONV_CYC = CONV_TIME_NS / CORE_PERIOD_NS;
    // ==========================================================
    // Carriers
    typedef struct packed
    {
        logic start;
        logic [2:0] chan;
        logic unipolar;
        logic single_ended;
        logic mode_select_high;
        logic mode_select_low;
    } sac_ctl_t;
    typedef struct packed
    {
        logic [2:0] chan;
        logic unipolar;
        logic single_ended;
    } sac_cfg_t;
    localparam sac_cfg_t CFG_RST = 5'h00; // Channel 0, bipolar, differential
endpackage

// [rtl/sac_sync2.sv]
// Two flip-flop synchroniser for levels or quasi-static words.
// Assumes a word only changes while its reader ignores it.
`timescale 1ns/10ps
module sac_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta; // First stage, read by the second only

    // ==========================================================
    // Two stages
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta <= '0;
            q_out <= '0;
        end
        else
        begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule // sac_sync2

// [rtl/sac_int_conv.sv]
// Internal clock conversion timer, result register and strobe.
// Assumes start_in is a one-cycle pulse on the core clock.
`timescale 1ns/10ps
module sac_int_conv (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic unipolar_in,
    input wire logic [sac_pkg::DEC_BITS-1:0] code_in,
    output logic strobe_out,
    output logic busy_out,
    output logic [sac_pkg::DEC_BITS-1:0] result_out
);
    import sac_pkg::*;
    localparam int CHK_N = CONV_CYC; // Strobe low span for checking
    logic [7:0] cnt; // Cycles left in the conversion
    logic [DEC_BITS-1:0] fmt; // Coded result

    // Bipolar flips the sign bit of the offset code
    assign fmt = code_in ^ (unipolar_in ? 12'h000 : SIGN_FLIP); // R5

    // ==========================================================
    // Conversion sequencer; a start while busy is ignored
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            strobe_out <= RST_STROBE; // R26
            busy_out <= 1'h0;
            cnt <= 8'h00;
            result_out <= '0;
        end
        else if (start_in && !busy_out)
        begin
            strobe_out <= 1'h0; // R14
            busy_out <= 1'h1;
            cnt <= 8'(CONV_CYC - 1);
            result_out <= '0;
        end
        else if (busy_out && cnt == 8'h00)
        begin
            strobe_out <= 1'h1; // R14
            busy_out <= 1'h0;
            result_out <= fmt; // R16
        end
        else if (busy_out)
        begin
            cnt <= cnt - 8'h01;
        end
    end

    // ==========================================================
    // Checks
    chk_strobe_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R14
        start_in && !busy_out |=> !strobe_out && busy_out)
        else $error("strobe did not fall at conversion start");
    chk_conv_span: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R14
        $fell(strobe_out) |-> ##[CHK_N:CHK_N] $rose(strobe_out))
        else $error("internal conversion length wrong");
    chk_result_code: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        $rose(strobe_out) |->
        result_out == ($past(code_in) ^ ($past(unipolar_in) ? 12'h000 : SIGN_FLIP)))
        else $error("result coding wrong");
    cov_int_conv: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(strobe_out));
endmodule // sac_int_conv

// [rtl/sac_top.sv]
// Serial control and readout of a successive-approximation converter.
// Assumes a master drives cs_n_in, sclk_in and din_in, sampling dout
// on rising edges; the converter core supplies adc_code_in.
// How it works
// R1 - Master sends start, config, two mode bits
// R2 - Master reads control, then two result bytes
// R3 - Readout: zero, result, sub-LSBs, three zeros
// R4 - Master keeps clocked conversion inside droop limit
// R5 - Unipolar straight binary, bipolar two's complement
// R6 - Result shifts out on falling edges, MSB first
// R7 - Track during the last three control bits
// R8 - Last two control bits pick clock mode
// R9 - Mode bits: full, fast, internal, external
// R10 - External strobe pulses one clock after control
// R11 - Twelve decisions on next twelve falling edges
// R12 - External: pins float while deselected, strobe low
// R13 - Master keeps clock between set rate limits
// R14 - Internal strobe low while converting
// R15 - Master holds clock low during internal conversion
// R16 - Internal result held; MSB on first fall
// R17 - Deselect blocks input, floats output, keeps conversion
// R18 - Internal mode strobe keeps driving when deselected
// R19 - Fast internal shifting needs long enough acquisition
// R20 - Select does not start; first one does
// R21 - Conversion starts on fall after eighth bit
// R22 - Start accepted when idle or after bit 3
// R23 - Select toggle abandons conversion, rearms start
// R24 - Overlapped conversions every 15 or 16 clocks
// R25 - Master clocks sixteen zeros when select tied
// R26 - Reset: internal mode, strobe high, zeros out
// R27 - Channel and input mode held during conversion
`timescale 1ns/10ps
module sac_top (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic din_in,
    input wire logic [sac_pkg::DEC_BITS-1:0] adc_code_in,
    output logic dout_out,
    output logic dout_oe_out,
    output logic conversion_strobe_out,
    output logic conversion_strobe_oe_out,
    output logic track_out,
    output sac_pkg::sac_cfg_t cfg_out,
    output logic full_pd_out,
    output logic fast_pd_out,
    output logic ext_mode_out
);
    import sac_pkg::*;

    // ==========================================================
    // Core clock reset release
    logic rst_meta; // First reset stage
    logic rst_n_core; // Released reset used everywhere

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_meta <= 1'h0;
            rst_n_core <= 1'h0;
        end
        else
        begin
            rst_meta <= 1'h1;
            rst_n_core <= rst_meta;
        end
    end

    // ==========================================================
    // Link side resets
    // Frame state dies with chip select so a toggle always aborts
    logic frame_rst_n; // Reset or deselect
    logic int_busy; // Internal conversion running (core flop)
    logic rd_rst_n; // Holds the readout at its first bit
    assign frame_rst_n = rst_n_core & ~cs_n_in; // R23
    // Busy is a clean flop; the clock is idle while it is high
    assign rd_rst_n = rst_n_core & ~int_busy; // R16

    // ==========================================================
    // Link side registers
    logic collecting; // Shifting a control byte
    logic [3:0] in_cnt; // Control bits taken so far
    logic [CTL_BITS-2:0] ctl_shift; // Control bits so far
    logic ctl_tgl; // Flips when a control byte completes
    logic ctl_seen; // Falling-edge copy of ctl_tgl
    logic conv_active; // External readout in progress
    logic [4:0] out_pos; // Frame bits already shown
    logic [FRAME_BITS-1:0] out_shift; // Frame bits still to show
    logic ext_strobe; // External mode strobe
    logic int_tgl; // Flips to start an internal conversion
    logic [4:0] rd_pos; // Internal readout position
    logic [DEC_BITS-1:0] link_code; // Converter code on the link clock
    logic [DEC_BITS-1:0] int_result; // Held internal result (core flop)
    logic int_strobe; // Internal mode strobe (core flop)

    // ==========================================================
    // Link decoding
    sac_ctl_t ctl_next; // Control byte as it completes
    logic cap_ctl; // Eighth bit arriving now
    logic armed; // A one may be taken as start
    logic go; // Conversion begins at this falling edge
    logic next_ext; // Clock mode after this control byte
    logic [DEC_BITS-1:0] ext_fmt; // Coded external result
    logic [FRAME_BITS-1:0] ext_frame; // Whole external frame
    logic [FRAME_BITS-1:0] int_frame; // Whole internal frame
    logic [FRAME_BITS-1:0] int_left; // Internal bits not yet shown

    assign ctl_next = {ctl_shift, din_in};
    assign cap_ctl = collecting && in_cnt == CTL_LAST;
    // Idle, or past result bit 3 of a running readout
    assign armed = !conv_active || out_pos >= REARM_POS; // R22 R24
    assign go = ctl_tgl != ctl_seen; // R21
    // Power-down codes keep the last clock mode
    assign next_ext = ctl_next.mode_select_high ? ctl_next.mode_select_low
        : ext_mode_out; // R8
    assign ext_fmt = link_code ^ (cfg_out.unipolar ? 12'h000 : SIGN_FLIP); // R5
    assign ext_frame = {1'h0, ext_fmt, 3'h0}; // R3
    assign int_frame = {int_result, 4'h0};
    assign int_left = int_frame << rd_pos;

    // Converter code seen by external conversions
    sac_sync2 #(
        .WIDTH(DEC_BITS)
    ) u_link_code (
        .clk_in(sclk_in),
        .rst_n_in(rst_n_core),
        .d_in(adc_code_in),
        .q_out(link_code)
    );

    // ==========================================================
    // Control byte intake on rising edges
    // Deselect clears this, so input shifting stops while high
    always_ff @(posedge sclk_in or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            collecting <= 1'h0; // R17
            in_cnt <= 4'h0;
            ctl_shift <= '0;
            ctl_tgl <= 1'h0;
            track_out <= 1'h0;
        end
        else if (!collecting)
        begin
            // Zeros before the start bit are ignored
            if (din_in && armed) // R20
            begin
                collecting <= 1'h1;
                in_cnt <= 4'h1;
                ctl_shift <= {{(CTL_BITS-2){1'h0}}, 1'h1};
            end
            track_out <= 1'h0;
        end
        else
        begin
            ctl_shift <= {ctl_shift[CTL_BITS-3:0], din_in};
            in_cnt <= in_cnt + 4'h1;
            // Track while the last three bits come in; ends as the eighth lands
            track_out <= in_cnt >= TRACK_FIRST && !cap_ctl; // R7
            if (cap_ctl)
            begin
                collecting <= 1'h0;
                ctl_tgl <= ~ctl_tgl;
            end
        end
    end

    // ==========================================================
    // Configuration; survives deselect for internal readout
    always_ff @(posedge sclk_in or negedge rst_n_core)
    begin
        if (!rst_n_core)
        begin
            cfg_out <= CFG_RST;
            ext_mode_out <= RST_EXT_MODE; // R26
            full_pd_out <= 1'h0;
            fast_pd_out <= 1'h0;
        end
        else if (cap_ctl && !cs_n_in)
        begin
            // Held until the next control byte completes
            cfg_out <= {ctl_next.chan, ctl_next.unipolar, ctl_next.single_ended}; // R27
            ext_mode_out <= next_ext; // R8
            full_pd_out <= {ctl_next.mode_select_high, ctl_next.mode_select_low}
                == MODE_FULL_PD; // R9
            fast_pd_out <= {ctl_next.mode_select_high, ctl_next.mode_select_low}
                == MODE_FAST_PD; // R9
        end
    end

    // ==========================================================
    // Output frame on falling edges
    always_ff @(negedge sclk_in or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            ctl_seen <= 1'h0;
            conv_active <= 1'h0; // R23
            out_pos <= 5'h00;
            out_shift <= '0;
            ext_strobe <= 1'h0; // R12
            dout_out <= 1'h0;
        end
        else if (go && ext_mode_out)
        begin
            // External start: strobe up, leading zero out
            ctl_seen <= ctl_tgl;
            conv_active <= 1'h1;
            out_pos <= 5'h01;
            out_shift <= {ext_frame[FRAME_BITS-2:0], 1'h0};
            ext_strobe <= 1'h1; // R10
            dout_out <= ext_frame[FRAME_BITS-1]; // R3
        end
        else if (conv_active && out_pos != FRAME_END)
        begin
            // One decision per falling edge, MSB first
            ctl_seen <= ctl_tgl;
            out_pos <= out_pos + 5'h01;
            out_shift <= {out_shift[FRAME_BITS-2:0], 1'h0};
            ext_strobe <= 1'h0; // R10
            dout_out <= out_shift[FRAME_BITS-1]; // R11 R6
        end
        else
        begin
            // Internal result, or zeros before any conversion
            ctl_seen <= ctl_tgl;
            conv_active <= 1'h0;
            ext_strobe <= 1'h0;
            dout_out <= int_left[FRAME_BITS-1]; // R16
        end
    end

    // ==========================================================
    // Internal start request; kept across deselect
    always_ff @(negedge sclk_in or negedge rst_n_core)
    begin
        if (!rst_n_core)
        begin
            int_tgl <= 1'h0;
        end
        else if (go && !ext_mode_out && !cs_n_in)
        begin
            int_tgl <= ~int_tgl; // R14
        end
    end

    // ==========================================================
    // Internal readout position
    // Held at zero while converting, so the first fall shows the MSB
    always_ff @(negedge sclk_in or negedge rd_rst_n)
    begin
        if (!rd_rst_n)
        begin
            rd_pos <= 5'h00; // R16
        end
        else if (!conv_active && !(go && ext_mode_out) && rd_pos != FRAME_END
            && !cs_n_in)
        begin
            rd_pos <= rd_pos + 5'h01;
        end
    end

    // ==========================================================
    // Core side of the internal conversion
    logic start_sync; // Synchronised start toggle
    logic start_prev; // Previous toggle value
    logic start_pulse; // One core cycle per request
    logic uni_sync; // Synchronised coding choice
    logic [DEC_BITS-1:0] core_code; // Synchronised converter code

    sac_sync2 #(
        .WIDTH(1)
    ) u_start_sync (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_core),
        .d_in(int_tgl),
        .q_out(start_sync)
    );

    sac_sync2 #(
        .WIDTH(1)
    ) u_uni_sync (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_core),
        .d_in(cfg_out.unipolar),
        .q_out(uni_sync)
    );

    sac_sync2 #(
        .WIDTH(DEC_BITS)
    ) u_core_code (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_core),
        .d_in(adc_code_in),
        .q_out(core_code)
    );

    // Toggle edge marks the request
    always_ff @(posedge core_clk_in or negedge rst_n_core)
    begin
        if (!rst_n_core)
        begin
            start_prev <= 1'h0;
        end
        else
        begin
            start_prev <= start_sync;
        end
    end
    assign start_pulse = start_sync ^ start_prev;

    // Chip select is not seen here, so deselect cannot disturb it
    sac_int_conv u_int_conv (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_core),
        .start_in(start_pulse),
        .unipolar_in(uni_sync),
        .code_in(core_code),
        .strobe_out(int_strobe),
        .busy_out(int_busy),
        .result_out(int_result)
    ); // R17

    // ==========================================================
    // Pin drive
    // The strobe pin is shared by both clock domains, one per mode
    assign conversion_strobe_out = ext_mode_out ? ext_strobe : int_strobe;
    assign conversion_strobe_oe_out = ext_mode_out ? !cs_n_in : 1'h1; // R18
    assign dout_oe_out = !cs_n_in; // R12

    // ==========================================================
    // Checks on the link
    chk_start_ignore: assert property (@(posedge sclk_in) disable iff (!frame_rst_n) // R20
        !collecting && !din_in |=> !collecting)
        else $error("start taken without a one");
    chk_rearm_block: assert property (@(posedge sclk_in) disable iff (!frame_rst_n) // R22
        !collecting && conv_active && out_pos < REARM_POS |=> !collecting)
        else $error("start taken before bit 3 out");
    chk_track_window: assert property (@(posedge sclk_in) disable iff (!frame_rst_n) // R7
        collecting && in_cnt == TRACK_FIRST |=> track_out [*3] ##1 !track_out)
        else $error("tracking window wrong");
    chk_mode_decode: assert property (@(posedge sclk_in) disable iff (!frame_rst_n) // R9
        cap_ctl && !ctl_shift[0] && !din_in |=> full_pd_out && !fast_pd_out)
        else $error("full power-down not decoded");
    chk_strobe_pulse: assert property (@(negedge sclk_in) disable iff (!frame_rst_n) // R10
        $rose(ext_strobe) |=> !ext_strobe)
        else $error("external strobe not one period");
    chk_lead_zero: assert property (@(negedge sclk_in) disable iff (!frame_rst_n) // R3
        $rose(ext_strobe) |-> !dout_out && out_pos == 5'h01)
        else $error("leading zero missing");
    chk_msb_first: assert property (@(negedge sclk_in) disable iff (!frame_rst_n) // R11
        $rose(ext_strobe) |=> dout_out == $past(ext_fmt[DEC_BITS-1], 2))
        else $error("MSB not first after strobe");
    chk_trail_zero: assert property (@(negedge sclk_in) disable iff (!frame_rst_n) // R3
        conv_active && out_pos >= TRAIL_POS |-> !dout_out)
        else $error("trailing zeros missing");
    cov_ext_frame: cover property (@(negedge sclk_in) disable iff (!frame_rst_n)
        conv_active && out_pos == FRAME_END);
    cov_overlap: cover property (@(negedge sclk_in) disable iff (!frame_rst_n)
        go && conv_active); // R24
endmodule // sac_top

// [verification/sac_master_model.sv]
// Serial master model: drives select, clock and data, captures readout.
// Assumes the device samples din on clock rise and shifts out on fall.
`timescale 1ns/10ps
module sac_master_model (
    output logic sclk_out,
    output logic cs_n_out,
    output logic din_out,
    input wire logic dout_in,
    input wire logic strobe_in,
    input wire logic track_in
);
    // ==========================================================
    // Capture shift registers, newest sample in bit 0
    logic [63:0] rx; // Data pin
    logic [63:0] st; // Strobe pin
    logic [63:0] tk; // Track window
    initial
    begin
        sclk_out = 1'h0; // Clock stands still outside frames
        cs_n_out = 1'h1;
        din_out = 1'h0;
    end
    // Change select with a settling gap on both sides
    task automatic sel(input logic lvl);
        #20;
        cs_n_out = lvl;
        #20;
    endtask
    // Frame of n bits MSB first, 15 ns period, back to back so it stays
    // far inside the hold droop limit; the rate is scaled up to keep runs
    // short, and the design has no minimum rate; samples just before each rise
    task automatic xfer(input int n, input logic [63:0] tx);
        rx = 64'h0;
        st = 64'h0;
        tk = 64'h0;
        for (int i = n - 1; i >= 0; i--)
        begin
            din_out = tx[i];
            #7.5;
            rx = {rx[62:0], dout_in};
            st = {st[62:0], strobe_in};
            tk = {tk[62:0], track_in};
            sclk_out = 1'h1;
            #7.5;
            sclk_out = 1'h0;
        end
    endtask
endmodule // sac_master_model

// [verification/test_sac_top.sv]
// Testbench of the serial converter interface with a master model.
// Assumes the design package and all design modules are compiled first.
`timescale 1ns/10ps
module test_sac_top;
    import sac_pkg::*;
    logic core_clk_in; // Set at time zero by the main sequence
    logic reset_n_in; // Asserted at time zero by the main sequence
    logic sclk, cs_n, din, dout, dout_oe, strobe, strobe_oe, track;
    logic full_pd, fast_pd, ext_mode;
    logic [DEC_BITS-1:0] code; // Quasi-static converter code, changed between tests
    sac_cfg_t cfg;
    int n_fail = 0;
    int comparisons = 0;
    int n;
    // Released pins show the inverse of the driven level, never a guess
    wire dout_w = dout_oe ? dout : ~dout;
    wire strobe_w = strobe_oe ? strobe : ~strobe;
    always #20 core_clk_in = ~core_clk_in;
    sac_top DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .din_in(din), .adc_code_in(code), .dout_out(dout),
        .dout_oe_out(dout_oe), .conversion_strobe_out(strobe),
        .conversion_strobe_oe_out(strobe_oe), .track_out(track), .cfg_out(cfg),
        .full_pd_out(full_pd), .fast_pd_out(fast_pd), .ext_mode_out(ext_mode));
    sac_master_model M (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout_w),
        .strobe_in(strobe_w), .track_in(track));
    // ==========================================================
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Bounded wait for a strobe level; cnt counts core cycles waited
    task automatic wait_strobe(input logic lvl, input int bound, output int cnt);
        cnt = 0;
        do
        begin
            @(negedge core_clk_in);
            cnt++;
        end while (strobe !== lvl && cnt < bound);
        if (strobe !== lvl)
        begin
            n_fail++;
            $display("[FAIL] strobe wait expected %0h seen %0h", lvl, strobe);
            end_sim();
        end
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        core_clk_in = 1'h0;
        reset_n_in = 1'h0;
        code = 12'hA5C;
        repeat (16) @(negedge core_clk_in);
        reset_n_in = 1'h1;
        repeat (4) @(negedge core_clk_in);
        chk("strobe", strobe, 1'h1);
        chk("ext_mode", ext_mode, 1'h0);
        chk("dout_oe", dout_oe, 1'h0);
        M.sel(1'h0);
        M.xfer(8, 64'h0);
        chk("reset_dout", M.rx[7:0], 8'h00);
        $display("test reset done");
        // Two conversions 16 clocks apart, the second start inside readout;
        // a one before bit 3 is out must be ignored
        M.xfer(40, {8'hDF, 8'h40, 8'hA3, 16'h0000});
        chk("res_uni", M.rx[31:16], {1'h0, code, 3'h0});
        chk("res_bip", M.rx[15:0], {1'h0, code ^ SIGN_FLIP, 3'h0});
        chk("strobe_pulse", M.st[31:30], 2'h2);
        chk("track", M.tk[36:31], 6'h0E);
        chk("cfg", cfg, 5'h08);
        chk("ext_mode", ext_mode, 1'h1);
        chk("strobe_ext", {strobe_oe, strobe}, 2'h2);
        M.sel(1'h1);
        chk("float_ext", {dout_oe, strobe_oe}, 2'h0);
        M.sel(1'h0);
        chk("strobe_sel", {strobe_oe, strobe}, 2'h2);
        $display("test external done");
        // Partial byte cut short by a select toggle, then power-down codes
        M.xfer(4, 64'hD);
        M.sel(1'h1);
        M.sel(1'h0);
        M.xfer(12, {4'h0, 8'h9D});
        chk("cfg_abort", cfg, 5'h07);
        chk("fast_pd", {full_pd, fast_pd, ext_mode}, 3'h3);
        M.sel(1'h1);
        M.sel(1'h0);
        M.xfer(8, 64'h80);
        chk("full_pd", {full_pd, fast_pd, cfg}, 7'h40);
        M.sel(1'h1);
        M.sel(1'h0);
        $display("test abort done");
        // Internal clock conversion while deselected, on a new code
        @(negedge core_clk_in);
        code = 12'h3B1;
        M.xfer(8, 64'hF2);
        M.sel(1'h1);
        chk("int_strobe_oe", strobe_oe, 1'h1);
        chk("int_mode", {ext_mode, dout_oe}, 2'h0);
        wait_strobe(1'h0, 20, n);
        wait_strobe(1'h1, 400, n);
        chk("conv_cycles", n, CONV_CYC);
        M.sel(1'h0);
        M.xfer(13, 64'h0);
        chk("int_result", M.rx[11:0], code ^ SIGN_FLIP);
        M.sel(1'h1);
        $display("test internal done");
        end_sim();
    end
endmodule // test_sac_top
